/* File: common/adc_cfg_pkg.sv */
package adc_cfg_pkg;

	// frame layout on the serial line
	localparam int          FRAME_BITS   = 32;
	localparam int          HEADER_BITS  = 12;
	localparam int          ADDR_BITS    = 4;
	localparam int          DATA_BITS    = 16;
	localparam int          PAYLOAD_BITS = ADDR_BITS + DATA_BITS;
	localparam logic [11:0] FRAME_HEADER = 12'h001;

	// bit counter positions inside one frame
	localparam logic [4:0] HEADER_END_INDEX = 5'h0b;
	localparam logic [4:0] ADDR_END_INDEX   = 5'h0f;
	localparam logic [4:0] LAST_BIT_INDEX   = 5'h1f;
	localparam logic [3:0] HEADER_TOP_INDEX = 4'hb;

	// register addresses
	localparam logic [3:0] ADDR_CONFIG     = 4'h1;
	localparam logic [3:0] ADDR_I_OFFSET   = 4'h2;
	localparam logic [3:0] ADDR_I_GAIN     = 4'h3;
	localparam logic [3:0] ADDR_Q_OFFSET   = 4'ha;
	localparam logic [3:0] ADDR_Q_GAIN     = 4'hb;
	localparam logic [3:0] ADDR_DES_ENABLE = 4'hd;
	localparam logic [3:0] ADDR_DES_COARSE = 4'he;

	// power-on values
	localparam logic [15:0] CONFIG_RESET   = 16'hb2ff;
	localparam logic [15:0] I_OFFSET_RESET = 16'h007f;
	localparam logic [15:0] I_GAIN_RESET   = 16'h807f;

	// configuration field positions
	localparam int CFG_DUTY_BIT  = 12;
	localparam int CFG_PHASE_BIT = 11;
	localparam int CFG_SDR_BIT   = 10;
	localparam int CFG_SWING_BIT = 9;
	localparam int CFG_EDGE_BIT  = 8;

	// trim field positions
	localparam int OFS_MAG_HI   = 15;
	localparam int OFS_MAG_LO   = 8;
	localparam int OFS_SIGN_BIT = 7;
	localparam int GAIN_HI      = 15;
	localparam int GAIN_LO      = 7;

	// values presented while pin control is in force
	localparam logic [7:0] OFS_MAG_NEUTRAL = 8'h00;
	localparam logic [8:0] GAIN_NEUTRAL    = 9'h100;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] data;
	} frame_word_type;

	typedef enum logic [3:0] {
		PH_HEADER  = 4'b0001,
		PH_ADDR    = 4'b0010,
		PH_DATA    = 4'b0100,
		PH_DISCARD = 4'b1000
	} frame_phase_type;

endpackage

/* File: src/bit_sync.sv */
`timescale 1ns/10ps
module bit_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg [STAGES];

	if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
		$error("bit_sync needs at least two stages and one bit");
	end

	// only the next stage reads stage 0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= '0;
			end
		end else begin
			stage_reg[0] <= async_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_reg[i] <= stage_reg[i-1];
			end
		end
	end

	assign sync_out = stage_reg[STAGES-1];
endmodule

/* File: src/adc_serial_config_port.sv */
`timescale 1ns/10ps
// Summary of operation
// - serial writes count only in extended mode
// - data sampled on serial clock rising edge
// - frame: 12-bit header, address, data
// - address then data, both msb first
// - held select: bit 33 starts next frame
// - decode config, trims, q and des addresses
// - write-only registers, inert in pin mode
// - reset values b2ff, 007f, 807f
// - bit 12 enables duty-cycle stabilizer
// - bit 11 sets ddr clock phase
// - bit 10 selects single or double rate
// - bit 9 selects output swing
// - bit 8 selects sdr data edge
// - offset bits 15:8 give magnitude
// - offset bit 7 gives sign
// - gain bits 15:7 give full-scale code
module adc_serial_config_port
	import adc_cfg_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        serial_clk,
	input  wire logic        serial_select_n,
	input  wire logic        serial_data,
	input  wire logic        range_or_mode_pin,
	input  wire logic        edge_select_pin,
	input  wire logic        swing_select_pin,
	input  wire logic        single_rate_pin,
	output logic             ext_mode_active,
	output logic             duty_stabilizer_en,
	output logic             ddr_clock_phase,
	output logic             single_rate_select,
	output logic             output_swing_select,
	output logic             sdr_rising_edge,
	output logic [7:0]       offset_magnitude,
	output logic             offset_negative,
	output logic [8:0]       gain_code,
	output logic             aux_write_strobe,
	output logic [3:0]       aux_write_addr,
	output logic [15:0]      aux_write_data,
	output logic             frame_reject_pulse
);

	// ---------------- serial clock domain ----------------
	logic                    link_rst_n;
	logic [4:0]              bit_cnt_reg;
	frame_phase_type         phase_reg;
	frame_phase_type         phase_next;
	logic [PAYLOAD_BITS-2:0] shift_reg;
	frame_word_type          hold_reg;
	logic                    commit_toggle_reg;
	logic                    reject_toggle_reg;
	logic [3:0]              header_index;
	logic                    header_bit_expected;
	logic                    frame_done;
	logic                    header_bad;

	// released select ends the frame at once, so a short frame never lingers
	// in the counter; the serial clock may stop between frames
	assign link_rst_n = rst_n & ~serial_select_n;

	assign header_index        = HEADER_TOP_INDEX - bit_cnt_reg[3:0];
	assign header_bit_expected = FRAME_HEADER[header_index];
	assign header_bad          = (phase_reg == PH_HEADER) &&
	                             (serial_data != header_bit_expected);
	assign frame_done          = (phase_reg == PH_DATA) && (bit_cnt_reg == LAST_BIT_INDEX);

	// 5-bit counter wraps after bit 32 so a held select runs frames back to back
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_reg <= 5'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PH_HEADER: begin
				if (header_bad) begin
					phase_next = PH_DISCARD;
				end else if (bit_cnt_reg == HEADER_END_INDEX) begin
					phase_next = PH_ADDR;
				end
			end
			PH_ADDR: begin
				if (bit_cnt_reg == ADDR_END_INDEX) begin
					phase_next = PH_DATA;
				end
			end
			PH_DATA: begin
				if (bit_cnt_reg == LAST_BIT_INDEX) begin
					phase_next = PH_HEADER;
				end
			end
			PH_DISCARD: begin
				if (bit_cnt_reg == LAST_BIT_INDEX) begin
					phase_next = PH_HEADER;
				end
			end
			default: begin
				phase_next = PH_HEADER;
			end
		endcase
	end

	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase_reg <= PH_HEADER;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// address bits then data bits enter at the bottom, msb arrives first
	always_ff @(posedge serial_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_reg <= '0;
		end else if (phase_reg == PH_ADDR || phase_reg == PH_DATA) begin
			shift_reg <= {shift_reg[PAYLOAD_BITS-3:0], serial_data};
		end
	end

	// hold word and toggles survive select release; only power-on clears them
	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg          <= '0;
			commit_toggle_reg <= 1'b0;
		end else if (frame_done) begin
			hold_reg          <= {shift_reg, serial_data};
			commit_toggle_reg <= ~commit_toggle_reg;
		end
	end

	always_ff @(posedge serial_clk or negedge rst_n) begin
		if (!rst_n) begin
			reject_toggle_reg <= 1'b0;
		end else if (header_bad) begin
			reject_toggle_reg <= ~reject_toggle_reg;
		end
	end

	// ---------------- reference clock domain ----------------
	logic [5:0]     sync_vec;
	logic           commit_sync;
	logic           reject_sync;
	logic           mode_sync;
	logic           edge_pin_sync;
	logic           swing_pin_sync;
	logic           rate_pin_sync;
	logic           commit_seen_reg;
	logic           reject_seen_reg;
	logic           commit_pulse;
	logic           commit_ok;
	logic           is_aux_addr;
	frame_word_type word;
	logic [15:0]    config_reg;
	logic [15:0]    i_offset_reg;
	logic [15:0]    i_gain_reg;

	bit_sync #(
		.WIDTH  (6),
		.STAGES (2)
	) bit_sync_inst (
		.clk      (ref_clk),
		.rst_n    (rst_n),
		.async_in ({commit_toggle_reg, reject_toggle_reg, range_or_mode_pin,
		            edge_select_pin, swing_select_pin, single_rate_pin}),
		.sync_out (sync_vec)
	);

	assign commit_sync    = sync_vec[5];
	assign reject_sync    = sync_vec[4];
	assign mode_sync      = sync_vec[3];
	assign edge_pin_sync  = sync_vec[2];
	assign swing_pin_sync = sync_vec[1];
	assign rate_pin_sync  = sync_vec[0];

	// the hold word is read only after its toggle has crossed, by then it is
	// settled; a serial clock fast enough to finish another frame within
	// three reference cycles would overrun this
	assign word         = hold_reg;
	assign commit_pulse = commit_sync ^ commit_seen_reg;
	assign commit_ok    = commit_pulse & mode_sync;
	assign is_aux_addr  = (word.addr == ADDR_Q_OFFSET) || (word.addr == ADDR_Q_GAIN) ||
	                      (word.addr == ADDR_DES_ENABLE) || (word.addr == ADDR_DES_COARSE);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			commit_seen_reg <= 1'b0;
			reject_seen_reg <= 1'b0;
		end else begin
			commit_seen_reg <= commit_sync;
			reject_seen_reg <= reject_sync;
		end
	end

	// write-only: none of these has a path back to the serial line
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_reg <= CONFIG_RESET;
		end else if (commit_ok && word.addr == ADDR_CONFIG) begin
			config_reg <= word.data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			i_offset_reg <= I_OFFSET_RESET;
		end else if (commit_ok && word.addr == ADDR_I_OFFSET) begin
			i_offset_reg <= word.data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			i_gain_reg <= I_GAIN_RESET;
		end else if (commit_ok && word.addr == ADDR_I_GAIN) begin
			i_gain_reg <= word.data;
		end
	end

	// q-channel and des words go out to their own holders; reserved ones die here
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_write_strobe <= 1'b0;
			aux_write_addr   <= 4'h0;
			aux_write_data   <= 16'h0000;
		end else begin
			aux_write_strobe <= commit_ok && is_aux_addr;
			if (commit_ok && is_aux_addr) begin
				aux_write_addr <= word.addr;
				aux_write_data <= word.data;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_reject_pulse <= 1'b0;
		end else begin
			frame_reject_pulse <= reject_sync ^ reject_seen_reg;
		end
	end

	// outputs follow the registers in extended mode, phase only at double rate; otherwise rate, swing and edge follow the pins, duty and phase are fixed;
	// stored values are kept so a mode change would not lose them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_mode_active     <= 1'b0;
			duty_stabilizer_en  <= CONFIG_RESET[CFG_DUTY_BIT];
			ddr_clock_phase     <= 1'b0;
			single_rate_select  <= 1'b0;
			output_swing_select <= CONFIG_RESET[CFG_SWING_BIT];
			sdr_rising_edge     <= 1'b0;
		end else if (mode_sync) begin
			ext_mode_active     <= 1'b1;
			duty_stabilizer_en  <= config_reg[CFG_DUTY_BIT];
			ddr_clock_phase     <= config_reg[CFG_PHASE_BIT] & ~config_reg[CFG_SDR_BIT];
			single_rate_select  <= config_reg[CFG_SDR_BIT];
			output_swing_select <= config_reg[CFG_SWING_BIT];
			sdr_rising_edge     <= config_reg[CFG_EDGE_BIT];
		end else begin
			ext_mode_active     <= 1'b0;
			duty_stabilizer_en  <= CONFIG_RESET[CFG_DUTY_BIT];
			ddr_clock_phase     <= 1'b0;
			single_rate_select  <= rate_pin_sync;
			output_swing_select <= swing_pin_sync;
			sdr_rising_edge     <= edge_pin_sync;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_magnitude <= I_OFFSET_RESET[OFS_MAG_HI:OFS_MAG_LO];
			offset_negative  <= I_OFFSET_RESET[OFS_SIGN_BIT];
			gain_code        <= I_GAIN_RESET[GAIN_HI:GAIN_LO];
		end else if (mode_sync) begin
			offset_magnitude <= i_offset_reg[OFS_MAG_HI:OFS_MAG_LO];
			offset_negative  <= i_offset_reg[OFS_SIGN_BIT];
			gain_code        <= i_gain_reg[GAIN_HI:GAIN_LO];
		end else begin
			offset_magnitude <= OFS_MAG_NEUTRAL;
			offset_negative  <= 1'b0;
			gain_code        <= GAIN_NEUTRAL;
		end
	end

	// ---------------- checks ----------------
	a_header_mismatch: assert property (
		@(posedge serial_clk) disable iff (!link_rst_n)
		header_bad |=> phase_reg == PH_DISCARD
	) else $error("bad header bit did not discard frame");

	a_address_follows: assert property (
		@(posedge serial_clk) disable iff (!link_rst_n)
		(phase_reg == PH_HEADER && bit_cnt_reg == HEADER_END_INDEX && serial_data)
		|=> phase_reg == PH_ADDR [*4] ##1 phase_reg == PH_DATA
	) else $error("address field not four bits after header");

	a_frame_wraps: assert property (
		@(posedge serial_clk) disable iff (!link_rst_n)
		bit_cnt_reg == LAST_BIT_INDEX |=> bit_cnt_reg == 5'h00 && phase_reg == PH_HEADER
	) else $error("frame did not restart after bit 32");

	a_commit_whole: assert property (
		@(posedge serial_clk) disable iff (!rst_n)
		commit_toggle_reg != $past(commit_toggle_reg)
		|-> $past(phase_reg) == PH_DATA && $past(bit_cnt_reg) == LAST_BIT_INDEX
	) else $error("commit without a complete frame");

	a_reset_values: assert property (
		@(posedge ref_clk)
		!rst_n |-> config_reg == CONFIG_RESET && i_offset_reg == I_OFFSET_RESET
		           && i_gain_reg == I_GAIN_RESET
	) else $error("register reset value wrong");

	a_pin_mode_ignores: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		commit_pulse && !mode_sync
		|=> $stable(config_reg) && $stable(i_offset_reg) && $stable(i_gain_reg)
		    && !aux_write_strobe
	) else $error("write taken in pin-controlled mode");

	a_config_write: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		commit_ok && word.addr == ADDR_CONFIG |=> config_reg == $past(word.data)
	) else $error("configuration write lost");

	a_reserved_inert: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		commit_ok && word.addr != ADDR_CONFIG && word.addr != ADDR_I_OFFSET
		&& word.addr != ADDR_I_GAIN
		|=> $stable(config_reg) && $stable(i_offset_reg) && $stable(i_gain_reg)
	) else $error("write to other address changed a register");

	a_aux_strobe: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		aux_write_strobe |-> $past(commit_ok) && aux_write_addr == $past(word.addr)
	) else $error("aux strobe without matching write");

	a_duty_follows: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_sync |=> duty_stabilizer_en == $past(config_reg[CFG_DUTY_BIT])
	) else $error("duty stabilizer does not follow bit 12");

	a_phase_ddr_only: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ddr_clock_phase |-> !single_rate_select && ext_mode_active
	) else $error("ddr phase set outside ddr extended mode");

	a_rate_swing_edge: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_sync |=> single_rate_select == $past(config_reg[CFG_SDR_BIT])
		&& output_swing_select == $past(config_reg[CFG_SWING_BIT])
		&& sdr_rising_edge == $past(config_reg[CFG_EDGE_BIT])
	) else $error("output mode bits do not follow configuration");

	a_trim_follows: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		mode_sync |=> offset_magnitude == $past(i_offset_reg[OFS_MAG_HI:OFS_MAG_LO])
		&& offset_negative == $past(i_offset_reg[OFS_SIGN_BIT])
		&& gain_code == $past(i_gain_reg[GAIN_HI:GAIN_LO])
	) else $error("trim outputs do not follow registers");

	a_pin_mode_neutral: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		!mode_sync |=> gain_code == GAIN_NEUTRAL && offset_magnitude == OFS_MAG_NEUTRAL
		&& !ddr_clock_phase && !ext_mode_active
	) else $error("registers acted in pin-controlled mode");

endmodule

/* File: sim/host_serial_model.sv */
`timescale 1ns/10ps
module host_serial_model (
	output logic serial_clk,
	output logic serial_select_n,
	output logic serial_data
);
	initial begin
		serial_clk      = 1'b0;
		serial_select_n = 1'b1;
		serial_data     = 1'b0;
	end

	// the link clock stands low outside frames; the bench never calls this during a
	// calibration or around a mode change
	task automatic send_frame(
		input logic [11:0] hdr,
		input logic [3:0]  addr,
		input logic [15:0] data,
		input int          nbits,
		input bit          hold_select
	);
		logic [31:0] word;
		word = {hdr, addr, data};
		serial_select_n = 1'b0;
		for (int i = 31; i > 31 - nbits; i--) begin
			serial_data = word[i];
			#80 serial_clk = 1'b1;
			#80 serial_clk = 1'b0;
		end
		if (!hold_select) begin
			#37 serial_select_n = 1'b1;
			// no pull on the data line: show the inverse once released
			serial_data = ~serial_data;
		end
	endtask
endmodule

/* File: sim/adc_serial_config_port_tb.sv */
`timescale 1ns/10ps
module adc_serial_config_port_tb;
	import adc_cfg_pkg::*;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] data;
		logic [22:0] exp_out;
		logic        aux;
	} row_type;

	localparam logic [22:0] RST_EXT = {5'b10010, 8'h00, 1'b0, 9'h100};
	localparam logic [22:0] LAST    = {5'b10111, 8'h5a, 1'b0, 9'h100};

	logic        ref_clk, rst_n, serial_clk, serial_select_n, serial_data;
	logic        range_or_mode_pin, edge_select_pin, swing_select_pin, single_rate_pin;
	logic        ext_mode_active, duty_stabilizer_en, ddr_clock_phase, single_rate_select;
	logic        output_swing_select, sdr_rising_edge, offset_negative;
	logic        aux_write_strobe, frame_reject_pulse;
	logic [7:0]  offset_magnitude;
	logic [8:0]  gain_code;
	logic [3:0]  aux_write_addr;
	logic [15:0] aux_write_data;
	logic [22:0] obs;
	int          mismatches, samples_checked, aux_count, reject_count, cycles;

	// host rows keep the fixed ones and the safe gain range
	row_type rows [14] = '{
		'{4'h1, 16'ha8ff, {5'b01000, 8'h00, 1'b0, 9'h100}, 1'b0},
		'{4'h1, 16'hbfff, {5'b10111, 8'h00, 1'b0, 9'h100}, 1'b0},
		'{4'h2, 16'hffff, {5'b10111, 8'hff, 1'b1, 9'h100}, 1'b0},
		'{4'h2, 16'h5a7f, {5'b10111, 8'h5a, 1'b0, 9'h100}, 1'b0},
		'{4'h3, 16'h607f, {5'b10111, 8'h5a, 1'b0, 9'h0c0}, 1'b0},
		'{4'h3, 16'he07f, {5'b10111, 8'h5a, 1'b0, 9'h1c0}, 1'b0},
		'{4'h3, 16'h807f, LAST, 1'b0},
		'{4'h0, 16'h0000, LAST, 1'b0},
		'{4'h4, 16'h0000, LAST, 1'b0},
		'{4'hf, 16'h0000, LAST, 1'b0},
		'{4'ha, 16'h007f, LAST, 1'b1},
		'{4'hb, 16'h807f, LAST, 1'b1},
		'{4'hd, 16'hbfff, LAST, 1'b1},
		'{4'he, 16'h27ff, LAST, 1'b1}
	};

	assign obs = {duty_stabilizer_en, ddr_clock_phase, single_rate_select, output_swing_select,
		sdr_rising_edge, offset_magnitude, offset_negative, gain_code};

	adc_serial_config_port adc_serial_config_port_inst (
		.ref_clk            (ref_clk),
		.rst_n              (rst_n),
		.serial_clk         (serial_clk),
		.serial_select_n    (serial_select_n),
		.serial_data        (serial_data),
		.range_or_mode_pin  (range_or_mode_pin),
		.edge_select_pin    (edge_select_pin),
		.swing_select_pin   (swing_select_pin),
		.single_rate_pin    (single_rate_pin),
		.ext_mode_active    (ext_mode_active),
		.duty_stabilizer_en (duty_stabilizer_en),
		.ddr_clock_phase    (ddr_clock_phase),
		.single_rate_select (single_rate_select),
		.output_swing_select(output_swing_select),
		.sdr_rising_edge    (sdr_rising_edge),
		.offset_magnitude   (offset_magnitude),
		.offset_negative    (offset_negative),
		.gain_code          (gain_code),
		.aux_write_strobe   (aux_write_strobe),
		.aux_write_addr     (aux_write_addr),
		.aux_write_data     (aux_write_data),
		.frame_reject_pulse (frame_reject_pulse)
	);

	host_serial_model host_serial_model_inst (
		.serial_clk     (serial_clk),
		.serial_select_n(serial_select_n),
		.serial_data    (serial_data)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic final_report();
		if (mismatches == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (aux_write_strobe === 1'b1)
			aux_count++;
		if (frame_reject_pulse === 1'b1)
			reject_count++;
		// about 21000 cycles of traffic expected
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic check_vec(input string name, input logic [22:0] exp, input logic [22:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_cnt(input string name, input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// commit lands within about 5 ref cycles of the last bit; 12 leaves margin
	task automatic run_frame(input logic [11:0] hdr, input logic [3:0] addr,
		input logic [15:0] data, input int nbits, input bit hold);
		aux_count = 0;
		reject_count = 0;
		host_serial_model_inst.send_frame(hdr, addr, data, nbits, hold);
		repeat (12) @(negedge ref_clk);
	endtask

	task automatic do_reset(input logic mode);
		@(negedge ref_clk);
		rst_n = 1'b0;
		range_or_mode_pin = mode;
		repeat (8) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (8) @(negedge ref_clk);
	endtask

	initial begin
		// starts high so the first reset below is a clean falling edge
		rst_n = 1'b1;
		range_or_mode_pin = 1'b1;
		edge_select_pin = 1'b0;
		swing_select_pin = 1'b0;
		single_rate_pin = 1'b0;
		do_reset(1'b1);
		check_vec("reset outputs", RST_EXT, obs);
		check_vec("reset config", {7'h0, CONFIG_RESET},
			{7'h0, adc_serial_config_port_inst.config_reg});
		check_vec("mode", 23'h1, {22'h0, ext_mode_active});
		foreach (rows[i]) begin
			run_frame(FRAME_HEADER, rows[i].addr, rows[i].data, 32, 1'b0);
			check_vec("outputs", rows[i].exp_out, obs);
			check_cnt("aux strobes", int'(rows[i].aux), aux_count);
			if (rows[i].aux)
				check_vec("aux word", {3'h0, rows[i].addr, rows[i].data},
					{3'h0, aux_write_addr, aux_write_data});
		end
		run_frame(12'h003, ADDR_I_OFFSET, 16'h117f, 32, 1'b0);
		check_cnt("bad header rejects", 1, reject_count);
		check_vec("bad header outputs", LAST, obs);
		run_frame(FRAME_HEADER, ADDR_I_OFFSET, 16'h117f, 31, 1'b0);
		check_vec("short frame outputs", LAST, obs);
		check_cnt("short frame rejects", 0, reject_count);
		// held select, and the link clock stalls between the two frames
		run_frame(FRAME_HEADER, ADDR_I_OFFSET, 16'h117f, 32, 1'b1);
		run_frame(FRAME_HEADER, ADDR_I_GAIN, 16'h607f, 32, 1'b0);
		check_vec("back to back", {5'b10111, 8'h11, 1'b0, 9'h0c0}, obs);
		edge_select_pin = 1'b1;
		single_rate_pin = 1'b1;
		do_reset(1'b0);
		check_vec("pin outputs", {5'b10101, 8'h00, 1'b0, 9'h100}, obs);
		check_vec("pin mode", 23'h0, {22'h0, ext_mode_active});
		run_frame(FRAME_HEADER, ADDR_Q_OFFSET, 16'h007f, 32, 1'b0);
		check_cnt("pin aux strobes", 0, aux_count);
		run_frame(FRAME_HEADER, ADDR_I_OFFSET, 16'h337f, 32, 1'b0);
		check_vec("pin offset reg", {7'h0, I_OFFSET_RESET},
			{7'h0, adc_serial_config_port_inst.i_offset_reg});
		check_vec("pin outputs after", {5'b10101, 8'h00, 1'b0, 9'h100}, obs);
		final_report();
	end
endmodule
